// >>> rtl/dac_acq_ctrl.sv
/*
 * Acquisition control for a spread-spectrum despreader: dwell timing and
 * integrate-and-dump, threshold decision, code phase slipping, Doppler
 * region alternation, sequence select and restart, with an APB slave.
 * Assumes correlation samples arrive on pclk; pins are asynchronous.
 */
// Our own choices: the APB slave port and the register offsets.
// Behaviour
// - search flag when threshold not exceeded
// - lock flag whenever threshold exceeded, unqualified
// - restart clears sequence register and counters
// - low restart input equals button press
// - filtered three-level status: search, zero, lock
// - low select uses external sequence input
// - chip clock is oscillator divided by four
// - Doppler region level, inert in BPSK
// - dump low discharges integrator, high integrates
// - dwell mode picks fixed or variable timer
// - dump 11 us, synchronous integration 361 us
// - asynchronous integration set 40 us to 1 ms
// - mode selects UQPSK or BPSK parameters
// - quarter-chip steps while searching, stop at lock
// - UQPSK alternates Doppler offset each sweep
// - BPSK single search at nominal frequency
`timescale 1ns/1ps
`default_nettype none

module dac_acq_ctrl #(
    parameter int unsigned SYNC_INTEG_CYC = dac_pkg::SYNC_INTEG_CYC,
    parameter int unsigned DEBOUNCE_CYC = dac_pkg::DEBOUNCE_CYC,
    parameter int unsigned SWEEP_STEPS = 4092,
    parameter int unsigned FILTER_EVALS = 3,
    parameter int unsigned CORR_W = 16,
    parameter int unsigned LFSR_W = 10,
    parameter logic [15:0] NCO_INC = 16'h2000,
    parameter logic [15:0] DOP_INC = 16'h0040
) (
    input wire logic pclk,                         // bus and block clock
    input wire logic presetn,                      // async reset, active low
    input wire logic [7:0] paddr,                  // apb address
    input wire logic psel,                         // apb select
    input wire logic penable,                      // apb enable
    input wire logic pwrite,                       // apb direction
    input wire logic [31:0] pwdata,                // apb write data
    output logic [31:0] prdata,                    // apb read data
    output logic pready,                           // apb ready
    output logic pslverr,                          // apb error
    input wire logic [CORR_W-1:0] corr_sample,     // signed correlation sample
    input wire logic restart_button_n,             // pushbutton, low pressed
    input wire logic restart_input_n,              // restart connector, low active
    input wire logic external_sequence_select_n,   // low selects external code
    input wire logic external_sequence_input,      // external code chips
    output logic chip_clock_monitor,               // oscillator / 4
    output logic code_sequence_out,                // selected code
    output logic dump_cmd,                         // high integrate, low dump
    output logic search_ind,                       // search light
    output logic lock_ind,                         // lock light
    output logic [1:0] status_level,               // +1 search, 0 restart, -1 lock
    output logic doppler_region_indicator,         // searched Doppler region
    output logic bpsk_config                       // gains and loop set for bpsk
);
    localparam int unsigned ACC_W = dac_pkg::ACC_W;
    localparam int unsigned TW = 16;
    localparam int unsigned SW = $clog2(SWEEP_STEPS + 1);
    localparam int unsigned FW = $clog2(FILTER_EVALS + 1);

    // ------------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------------
    logic btn_n;
    logic conn_n;
    logic ext_sel_n;
    logic ext_chip;

    dac_pin_filter #(.STABLE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b1)) u_btn (
        .clk(pclk), .rst_n(presetn), .pin(restart_button_n), .level(btn_n));
    dac_pin_filter #(.STABLE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b1)) u_conn (
        .clk(pclk), .rst_n(presetn), .pin(restart_input_n), .level(conn_n));
    dac_pin_filter #(.STABLE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b1)) u_sel (
        .clk(pclk), .rst_n(presetn), .pin(external_sequence_select_n), .level(ext_sel_n));
    // code chips are only synchronised; debouncing would eat short chips
    dac_pin_filter #(.STABLE_CYC(1), .RESET_VAL(1'b0)) u_chip (
        .clk(pclk), .rst_n(presetn), .pin(external_sequence_input), .level(ext_chip));

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic [dac_pkg::DWELL_W-1:0] dwell_reg;
    logic [31:0] thr_u_reg;
    logic [31:0] thr_b_reg;
    logic sw_restart_reg;
    logic [ACC_W-1:0] acc_last_reg;

    logic mode_bpsk;
    logic mode_async;
    logic restart;
    logic wr_en;
    logic setup;

    assign mode_bpsk = ctrl_reg[dac_pkg::CTRL_BPSK];
    assign mode_async = ctrl_reg[dac_pkg::CTRL_ASYNC];
    assign restart = ~btn_n | ~conn_n | sw_restart_reg;
    assign wr_en = psel & penable & pwrite;
    assign setup = psel & ~penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= dac_pkg::CTRL_RST;
            dwell_reg <= dac_pkg::DWELL_RST;
            thr_u_reg <= dac_pkg::THR_RST;
            thr_b_reg <= dac_pkg::THR_RST;
            sw_restart_reg <= 1'b0;
        end else begin
            sw_restart_reg <= wr_en && paddr == dac_pkg::OFS_CTRL && pwdata[dac_pkg::CTRL_RESTART];
            if (wr_en) begin
                case (paddr)
                    dac_pkg::OFS_CTRL: ctrl_reg <= {pwdata[dac_pkg::CTRL_ASYNC], pwdata[dac_pkg::CTRL_BPSK]};
                    dac_pkg::OFS_DWELL: dwell_reg <= pwdata[dac_pkg::DWELL_W-1:0];
                    dac_pkg::OFS_THR_UQPSK: thr_u_reg <= pwdata;
                    dac_pkg::OFS_THR_BPSK: thr_b_reg <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // read data is captured in the setup cycle so the access phase needs no wait
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [5:0] status_bits;

    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (paddr)
            dac_pkg::OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_reg};
            dac_pkg::OFS_DWELL: rd_mux = {22'h00_0000, dwell_reg};
            dac_pkg::OFS_THR_UQPSK: rd_mux = thr_u_reg;
            dac_pkg::OFS_THR_BPSK: rd_mux = thr_b_reg;
            dac_pkg::OFS_STATUS: rd_mux = {26'h000_0000, status_bits};
            dac_pkg::OFS_ACC: rd_mux = acc_last_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~rd_hit;
            end
        end
    end

    // ------------------------------------------------------------------
    // tunable chip oscillator and divide-by-four
    // ------------------------------------------------------------------
    logic [15:0] nco_reg;
    logic [15:0] nco_inc;
    logic [16:0] nco_sum;
    logic slip_reg;
    logic [1:0] quarter_reg;
    logic osc_tick;
    logic adv_tick;
    logic chip_en;
    logic region_reg;

    always_comb begin
        if (mode_bpsk) begin
            nco_inc = NCO_INC;
        end else if (region_reg) begin
            nco_inc = NCO_INC - DOP_INC;
        end else begin
            nco_inc = NCO_INC + DOP_INC;
        end
    end

    assign nco_sum = {1'b0, nco_reg} + {1'b0, nco_inc};
    assign osc_tick = nco_sum[16];
    assign adv_tick = osc_tick & ~slip_reg;
    assign chip_en = adv_tick & (quarter_reg == 2'h3);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_reg <= '0;
            quarter_reg <= '0;
            chip_clock_monitor <= 1'b0;
        end else if (restart) begin
            nco_reg <= '0;
            quarter_reg <= '0;
            chip_clock_monitor <= 1'b0;
        end else begin
            nco_reg <= nco_sum[15:0];
            if (adv_tick) begin
                quarter_reg <= quarter_reg + 2'h1;
                chip_clock_monitor <= quarter_reg[0] ? ~chip_clock_monitor : chip_clock_monitor;
            end
        end
    end

    // ------------------------------------------------------------------
    // local sequence generator and source select
    // ------------------------------------------------------------------
    logic [LFSR_W-1:0] lfsr_reg;

    // xnor feedback keeps the all-zero cleared state legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_reg <= '0;
        end else if (restart) begin
            lfsr_reg <= '0;
        end else if (chip_en) begin
            lfsr_reg <= {lfsr_reg[LFSR_W-2:0], ~(lfsr_reg[LFSR_W-1] ^ lfsr_reg[LFSR_W-4])};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_sequence_out <= 1'b0;
        end else begin
            code_sequence_out <= ext_sel_n ? lfsr_reg[LFSR_W-1] : ext_chip;
        end
    end

    // ------------------------------------------------------------------
    // dwell timer and integrate-and-dump
    // ------------------------------------------------------------------
    dac_pkg::dac_dwell_e dw_reg;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] integ_len;
    logic [dac_pkg::DWELL_W-1:0] dwell_us;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] thr_sel;
    logic dump_end;
    logic eval;
    logic exceeds;
    logic [ACC_W-1:0] acc_sum;

    always_comb begin
        if (dwell_reg < dac_pkg::DWELL_W'(dac_pkg::ASYNC_MIN_US)) begin
            dwell_us = dac_pkg::DWELL_W'(dac_pkg::ASYNC_MIN_US);
        end else if (dwell_reg > dac_pkg::DWELL_W'(dac_pkg::ASYNC_MAX_US)) begin
            dwell_us = dac_pkg::DWELL_W'(dac_pkg::ASYNC_MAX_US);
        end else begin
            dwell_us = dwell_reg;
        end
    end

    assign integ_len = mode_async ? TW'(dwell_us * dac_pkg::CYC_PER_US) : TW'(SYNC_INTEG_CYC);
    assign dump_end = (dw_reg == dac_pkg::DW_DUMP) && (timer_reg >= TW'(dac_pkg::DUMP_CYC - 1));
    assign eval = (dw_reg == dac_pkg::DW_INTEG) && (timer_reg >= integ_len - TW'(1));
    assign thr_sel = mode_bpsk ? thr_b_reg : thr_u_reg;
    // the sample of the eval cycle is still integration time, so it is in the decision
    assign acc_sum = acc_reg + {{(ACC_W - CORR_W){corr_sample[CORR_W-1]}}, corr_sample};
    assign exceeds = $signed(acc_sum) > $signed(thr_sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dw_reg <= dac_pkg::DW_DUMP;
            timer_reg <= '0;
            dump_cmd <= 1'b0;
        end else if (restart) begin
            dw_reg <= dac_pkg::DW_DUMP;
            timer_reg <= '0;
            dump_cmd <= 1'b0;
        end else begin
            case (dw_reg)
                dac_pkg::DW_DUMP: begin
                    timer_reg <= dump_end ? '0 : timer_reg + TW'(1);
                    dw_reg <= dump_end ? dac_pkg::DW_INTEG : dac_pkg::DW_DUMP;
                    dump_cmd <= dump_end;
                end
                dac_pkg::DW_INTEG: begin
                    timer_reg <= eval ? '0 : timer_reg + TW'(1);
                    dw_reg <= eval ? dac_pkg::DW_DUMP : dac_pkg::DW_INTEG;
                    dump_cmd <= ~eval;
                end
                default: begin
                    dw_reg <= dac_pkg::DW_DUMP;
                    timer_reg <= '0;
                    dump_cmd <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= '0;
            acc_last_reg <= '0;
        end else if (restart || !dump_cmd) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_sum;
            if (eval) begin
                acc_last_reg <= acc_sum;
            end
        end
    end

    // ------------------------------------------------------------------
    // decision, stepping and Doppler alternation
    // ------------------------------------------------------------------
    logic [SW-1:0] sweep_reg;
    logic [FW-1:0] filt_cnt_reg;
    logic filt_last_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            search_ind <= 1'b1;
            lock_ind <= 1'b0;
        end else if (restart) begin
            search_ind <= 1'b1;
            lock_ind <= 1'b0;
        end else if (eval) begin
            search_ind <= ~exceeds;
            lock_ind <= exceeds;
        end
    end

    // a step that lands while a slip is pending wins over the slip being consumed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slip_reg <= 1'b0;
            sweep_reg <= '0;
            region_reg <= 1'b0;
        end else if (restart) begin
            slip_reg <= 1'b0;
            sweep_reg <= '0;
            region_reg <= 1'b0;
        end else begin
            if (eval && !exceeds) begin
                slip_reg <= 1'b1;
                if (sweep_reg >= SW'(SWEEP_STEPS - 1)) begin
                    sweep_reg <= '0;
                    region_reg <= mode_bpsk ? 1'b0 : ~region_reg;
                end else begin
                    sweep_reg <= sweep_reg + SW'(1);
                end
            end else if (osc_tick) begin
                slip_reg <= 1'b0;
            end
            if (mode_bpsk) begin
                region_reg <= 1'b0;
            end
        end
    end

    // low-pass on the status level: only a repeated decision moves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_level <= dac_pkg::LVL_RESTART;
            filt_cnt_reg <= '0;
            filt_last_reg <= 1'b0;
        end else if (restart) begin
            status_level <= dac_pkg::LVL_RESTART;
            filt_cnt_reg <= '0;
            filt_last_reg <= 1'b0;
        end else if (eval) begin
            if (exceeds != filt_last_reg) begin
                filt_last_reg <= exceeds;
                filt_cnt_reg <= FW'(1);
            end else if (filt_cnt_reg >= FW'(FILTER_EVALS - 1)) begin
                status_level <= exceeds ? dac_pkg::LVL_LOCK : dac_pkg::LVL_SEARCH;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + FW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doppler_region_indicator <= 1'b0;
            bpsk_config <= 1'b0;
        end else begin
            doppler_region_indicator <= region_reg;
            bpsk_config <= mode_bpsk;
        end
    end

    assign status_bits = {~ext_sel_n, dump_cmd, region_reg, restart, lock_ind, search_ind};

endmodule // dac_acq_ctrl

`default_nettype wire

// >>> rtl/dac_pkg.sv
/*
 * Shared constants for the despreader acquisition control block: register map,
 * field positions, reset values and dwell timing.
 * Assumes a 20 MHz pclk; all cycle counts are derived from that rate.
 */
package dac_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned PCLK_HZ = 20_000_000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;
    localparam int unsigned CYC_PER_US = PCLK_HZ / HZ_PER_MHZ;
    localparam int unsigned DUMP_US = 11;
    localparam int unsigned SYNC_INTEG_US = 361;
    localparam int unsigned ASYNC_MIN_US = 40;
    localparam int unsigned ASYNC_MAX_US = 1000;
    localparam int unsigned DUMP_CYC = DUMP_US * CYC_PER_US;
    localparam int unsigned SYNC_INTEG_CYC = SYNC_INTEG_US * CYC_PER_US;
    localparam int unsigned DEBOUNCE_US = 5000;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CYC_PER_US;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DWELL = 8'h04;
    localparam logic [7:0] OFS_THR_UQPSK = 8'h08;
    localparam logic [7:0] OFS_THR_BPSK = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ACC = 8'h14;

    // control fields
    localparam int unsigned CTRL_BPSK = 0;
    localparam int unsigned CTRL_ASYNC = 1;
    localparam int unsigned CTRL_RESTART = 2;

    // status fields
    localparam int unsigned ST_SEARCH = 0;
    localparam int unsigned ST_LOCK = 1;
    localparam int unsigned ST_RESTART = 2;
    localparam int unsigned ST_REGION = 3;
    localparam int unsigned ST_DUMP = 4;
    localparam int unsigned ST_EXTSEL = 5;

    // reset values and widths
    localparam int unsigned DWELL_W = 10;
    localparam int unsigned ACC_W = 32;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [DWELL_W-1:0] DWELL_RST = 10'h064;
    localparam logic [31:0] THR_RST = 32'h0000_4000;

    // three-level status code: positive, zero, negative
    localparam logic [1:0] LVL_SEARCH = 2'h1;
    localparam logic [1:0] LVL_RESTART = 2'h0;
    localparam logic [1:0] LVL_LOCK = 2'h3;

    // dwell states
    typedef enum logic [1:0] {
        DW_DUMP = 2'b01,
        DW_INTEG = 2'b10
    } dac_dwell_e;

endpackage

// >>> rtl/dac_pin_filter.sv
/*
 * Two-flop synchroniser followed by a stability filter for one pin.
 * Assumes the pin is asynchronous to clk; output changes only after the
 * synchronised level has held for STABLE_CYC cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module dac_pin_filter #(
    parameter int unsigned STABLE_CYC = 1,
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,     // block clock
    input wire logic rst_n,   // async reset, active low
    input wire logic pin,     // raw pin level
    output logic level        // filtered level
);
    localparam int unsigned CW = $clog2(STABLE_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

    logic meta_reg;
    logic sync_reg;
    logic [CW-1:0] cnt_reg;

    // first flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            level <= RESET_VAL;
        end else if (sync_reg == level) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= LAST) begin
            cnt_reg <= '0;
            level <= sync_reg;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

endmodule // dac_pin_filter

`default_nettype wire

// >>> dv/dac_acq_ctrl_assertions.sv
/* port checker for dac_acq_ctrl, bound into every instance
   assumes one clock domain: pclk with presetn */
`timescale 1ns/1ps
`default_nettype none
module dac_acq_chk (
    input wire logic pclk, presetn, psel, penable, pready, pslverr, restart_input_n, dump_cmd,
    input wire logic search_ind, lock_ind, bpsk_config, doppler_region_indicator, chip_clock_monitor,
    input wire logic [7:0] paddr, input wire logic [1:0] status_level);
    logic [15:0] lo_n;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // dump length is judged as it ends; a restart only makes it longer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lo_n <= 16'h0000;
        else lo_n <= dump_cmd ? 16'h0000 : lo_n + 16'h0001;
    end
    sequence s_pin_held; !restart_input_n [*8]; endsequence
    sequence s_setup; psel && !penable && paddr[1:0] == 2'b00; endsequence
    a_ind_exclusive: assert property (search_ind != lock_ind) else $error("search and lock clash");
    a_lock_at_eval: assert property ($rose(lock_ind) |-> $fell(dump_cmd)) else $error("lock off eval");
    a_level_legal: assert property (status_level != 2'b10) else $error("bad status level");
    a_dump_width: assert property ($rose(dump_cmd) |-> lo_n >= 16'h00DB) else $error("dump short");
    // a restart may pull the monitor low at any point of a half period
    a_chip_clk_half: assert property ($changed(chip_clock_monitor) |=>
        ($stable(chip_clock_monitor) || status_level == 2'b00) [*8]) else $error("chip clock fast");
    a_bpsk_region: assert property (bpsk_config ##1 bpsk_config |->
        !doppler_region_indicator) else $error("region in bpsk");
    a_pin_restart: assert property (s_pin_held |-> ##3 status_level == 2'b00
        && search_ind && !dump_cmd) else $error("restart pin ignored");
    a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
    a_unmapped_err: assert property (s_setup |=> pslverr == ($past(paddr) > 8'h14)) else $error("bad pslverr");
endmodule // dac_acq_chk
bind dac_acq_ctrl dac_acq_chk dac_acq_chk_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .restart_input_n, .dump_cmd, .search_ind, .lock_ind, .bpsk_config, .doppler_region_indicator,
    .chip_clock_monitor, .paddr, .status_level);
`default_nettype wire

// >>> dv/dac_far_side.sv
/* far side: restart connector and external code source
   assumes the bench asks for restarts and code bits on pclk */
`timescale 1ns/1ps
`default_nettype none
module dac_far_side (
    input wire logic pclk,                          // block clock
    input wire logic restart_req,                   // bench asks for restart
    input wire logic code_bit,                      // next external chip
    output var logic restart_input_n = 1'b1,        // connector, low restarts
    output var logic external_sequence_input = 1'b0 // external code
);
    always @(posedge pclk) begin
        restart_input_n <= !restart_req;
        external_sequence_input <= code_bit;
    end
endmodule // dac_far_side
`default_nettype wire

// >>> dv/tb_dac_acq_ctrl.sv
/* bench for dac_acq_ctrl: apb tasks, far side model, short counts
   assumes integration 200 cycles, debounce 4, sweep 8 */
`timescale 1ns/1ps
`default_nettype none
module tb_dac_acq_ctrl;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restart_button_n = 1'b1;
    logic external_sequence_select_n = 1'b1, restart_req = 1'b0, code_bit = 1'b0;
    logic pready, pslverr, restart_input_n, external_sequence_input, chip_clock_monitor, code_sequence_out;
    logic dump_cmd, search_ind, lock_ind, doppler_region_indicator, bpsk_config;
    logic [1:0] status_level;
    logic [7:0] paddr = 8'h00;
    logic [15:0] corr_sample = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [31:0] rst_tbl [5] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_4000, 32'h0000_4000, 32'h0000_0001};
    int err_total = 0, n_tests = 0, lo, hi, k;
    always #25 pclk = ~pclk;
    dac_far_side dac_far_side_inst (.pclk, .restart_req, .code_bit, .restart_input_n, .external_sequence_input);
    dac_acq_ctrl #(.SYNC_INTEG_CYC(200), .DEBOUNCE_CYC(4), .SWEEP_STEPS(8)) dac_acq_ctrl_inst (.pclk, .presetn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .corr_sample, .restart_button_n,
        .restart_input_n, .external_sequence_select_n, .external_sequence_input, .chip_clock_monitor,
        .code_sequence_out, .dump_cmd, .search_ind, .lock_ind, .status_level, .doppler_region_indicator,
        .bpsk_config);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // one dump and one integration, each measured in cycles; entered on a falling edge
    task automatic dwell();
        lo = 0;
        hi = 0;
        while (dump_cmd !== 1'b0) @(negedge pclk);
        while (dump_cmd === 1'b0) begin @(negedge pclk); lo++; end
        while (dump_cmd === 1'b1) begin @(negedge pclk); hi++; end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            check(rd, rst_tbl[i]);
        end
        apb(1'b0, 8'h18, 32'h0000_0000);
        check({rd[30:0], pslverr}, 32'h0000_0001);
        repeat (2) dwell();
        check(lo, 220);
        check(hi, 200);
        check({search_ind, lock_ind}, 2'b10);
        @(posedge pclk);
        corr_sample <= 16'h0100;
        @(negedge pclk);
        dwell();
        check({search_ind, lock_ind}, 2'b01);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_C800);
        apb(1'b1, 8'h08, 32'h0000_C800);
        dwell();
        check({search_ind, lock_ind}, 2'b10);
        apb(1'b1, 8'h08, 32'h0000_C7FF);
        repeat (3) dwell();
        check(status_level, 2'b11);
        $display("test decisions done");
        for (int s = 0; s < 3; s++) begin
            @(posedge pclk);
            restart_button_n <= (s != 0);
            restart_req <= (s == 1);
            if (s == 2) apb(1'b1, 8'h00, 32'h0000_0004);
            else repeat (12) @(posedge pclk);
            @(negedge pclk);
            check({search_ind, lock_ind, dump_cmd}, 3'b100);
            if (s < 2) check(status_level, 2'b00);
        end
        @(posedge pclk);
        restart_req <= 1'b0;
        external_sequence_select_n <= 1'b0;
        code_bit <= 1'b1;
        repeat (12) @(negedge pclk);
        check(code_sequence_out, 1'b1);
        @(posedge pclk);
        code_bit <= 1'b0;
        repeat (8) @(negedge pclk);
        check(code_sequence_out, 1'b0);
        @(posedge pclk);
        external_sequence_select_n <= 1'b1;
        corr_sample <= 16'h0000;
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        apb(1'b1, 8'h00, 32'h0000_0001);
        repeat (2) dwell();
        check({bpsk_config, doppler_region_indicator, lock_ind}, 3'b101);
        apb(1'b1, 8'h00, 32'h0000_0000);
        k = 0;
        // the region output trails the decision by one clock
        while (doppler_region_indicator !== 1'b1 && k < 20) begin dwell(); @(negedge pclk); k++; end
        check(k, 8);
        $display("test restart, select and modes done");
        apb(1'b1, 8'h04, 32'h0000_000A);
        apb(1'b1, 8'h00, 32'h0000_0002);
        repeat (2) dwell();
        check(hi, 800);
        apb(1'b1, 8'h04, 32'h0000_03FF);
        repeat (2) dwell();
        check(hi, 20000);
        check(lo, 220);
        $display("test async dwell done");
        tally_and_finish();
    end
    initial begin
        repeat (80000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end
endmodule // tb_dac_acq_ctrl
`default_nettype wire
